// ===== design/cpu_register_file.sv
// cpu register set, internal ram, aux ram and apb register access
`timescale 1ns/1ps
`default_nettype none
module cpu_register_file (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [cpu_regs_pkg::PROG_ADDR_W-1:0] prog_addr,
    input wire logic pc_load,
    input wire logic [15:0] pc_load_value,
    input wire logic pc_inc,
    input wire logic alu_valid,
    input wire logic alu_sub,
    input wire logic [7:0] alu_operand,
    input wire logic alu_use_carry,
    input wire logic shift_valid,
    input wire logic shift_carry,
    input wire logic [7:0] shift_result,
    input wire logic acc_we,
    input wire logic [7:0] acc_wdata,
    input wire logic b_we,
    input wire logic [7:0] b_wdata,
    input wire logic clear_overflow_instr,
    input wire logic bit_test_valid,
    input wire logic [7:0] bit_test_data,
    input wire logic stack_push,
    input wire logic stack_pop,
    input wire logic [7:0] stack_wdata,
    output logic [7:0] stack_rdata,
    input wire logic work_reg_we,
    input wire logic [2:0] work_reg_index,
    input wire logic [7:0] work_reg_wdata,
    output logic [7:0] work_reg_rdata,
    input wire logic bit_we,
    input wire logic [6:0] bit_addr,
    input wire logic bit_wdata,
    output logic bit_rdata,
    input wire logic data_pointer_we,
    input wire logic [15:0] data_pointer_wdata,
    input wire logic data_pointer_inc,
    input wire logic external_move_instr,
    input wire logic external_move_instr_write,
    input wire logic external_move_instr_use_data_pointer,
    input wire logic [7:0] external_move_instr_ri_addr,
    input wire logic [7:0] external_move_instr_wdata,
    output logic [7:0] external_move_instr_rdata,
    output logic [7:0] acc,
    output logic [7:0] b_reg,
    output logic [15:0] ba_pair,
    output logic [7:0] program_status_word
);
    import cpu_regs_pkg::*;

    logic [7:0] iram [IRAM_DEPTH];  // internal data ram, flip-flops
    logic [7:0] aux_ram [AUX_DEPTH];  // auxiliary ram, flip-flops
    logic [15:0] pc;  // program counter
    logic [7:0] stack_pointer;
    logic [15:0] data_pointer;
    logic [7:0] aux_ram_address_pointer;
    logic aux_ram_select;  // only stored bit of extended control
    logic carry_flag;
    logic aux_carry_flag;
    logic general_user_flag;
    logic bank_select_high;
    logic bank_select_low;
    logic overflow_flag;
    logic parity_flag;

    // apb decode; every access finishes in its first access cycle
    logic apb_access;
    logic apb_wr;
    logic apb_rd;
    logic win_hit;  // address falls in the internal ram window
    logic reg_hit;  // address matches a register word
    assign apb_access = psel && penable;
    assign apb_wr = apb_access && pwrite && !pslverr;
    assign apb_rd = apb_access && !pwrite && !pslverr;
    assign win_hit = (paddr[11:10] == IRAM_WINDOW_SEL) && (paddr[1:0] == 2'b00);
    assign pready = 1'b1;

    // register word decode
    always_comb begin
        case (paddr)
            OFS_STATUS, OFS_EXT_CTRL, OFS_ACC, OFS_B, OFS_STACK_PTR, OFS_DATA_PTR_LO,
            OFS_DATA_PTR_HI, OFS_PROG_CNT_LO, OFS_PROG_CNT_HI, OFS_AUX_PTR, OFS_AUX_BUF:
                reg_hit = 1'b1;
            default: reg_hit = 1'b0;
        endcase
    end
    // unmapped addresses answer with an error and change nothing
    assign pslverr = apb_access && !(reg_hit || win_hit);

    logic [7:0] ram_addr_w;  // ram word index from the window
    assign ram_addr_w = paddr[9:2];

    assign parity_flag = ~(^acc);

    assign program_status_word = {carry_flag, aux_carry_flag, general_user_flag,
                                  bank_select_high, bank_select_low, overflow_flag,
                                  1'b0, parity_flag};

    assign ba_pair = {b_reg, acc};

    // fetch address only, no write path
    assign prog_addr = pc[PROG_ADDR_W-1:0];

    // alu arithmetic on accumulator and operand
    logic cin;
    logic [8:0] add_full;
    logic [4:0] add_low;
    logic [7:0] op_eff;  // operand, inverted for subtraction
    logic [7:0] alu_result;
    assign cin = alu_sub ? ~(alu_use_carry & carry_flag) : (alu_use_carry & carry_flag);
    assign op_eff = alu_sub ? ~alu_operand : alu_operand;
    assign add_full = {1'b0, acc} + {1'b0, op_eff} + {8'h00, cin};
    assign add_low = {1'b0, acc[3:0]} + {1'b0, op_eff[3:0]} + {4'h0, cin};
    assign alu_result = add_full[7:0];

    // accumulator: alu first, then shift, then core write, then software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc <= 8'h00;
        end else if (alu_valid) begin
            acc <= alu_result;
        end else if (shift_valid) begin
            acc <= shift_result;
        end else if (acc_we) begin
            acc <= acc_wdata;
        end else if (apb_wr && paddr == OFS_ACC) begin
            acc <= pwdata[7:0];
        end
    end

    // b register, written by multiply/divide results from the core
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            b_reg <= 8'h00;
        end else if (b_we) begin
            b_reg <= b_wdata;
        end else if (apb_wr && paddr == OFS_B) begin
            b_reg <= pwdata[7:0];
        end
    end

    // carry and aux carry; hardware updates win over software writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            carry_flag <= STATUS_RESET[STAT_CARRY];
            aux_carry_flag <= STATUS_RESET[STAT_AUX_CARRY];
        end else if (alu_valid) begin
            carry_flag <= alu_sub ? add_full[8] : add_full[8];
            aux_carry_flag <= add_low[4];
        end else if (shift_valid) begin
            carry_flag <= shift_carry;
        end else if (apb_wr && paddr == OFS_STATUS) begin
            carry_flag <= pwdata[STAT_CARRY];
            aux_carry_flag <= pwdata[STAT_AUX_CARRY];
        end
    end

    // overflow flag; a set from the alu wins over a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_flag <= STATUS_RESET[STAT_OVF];
        end else if (alu_valid) begin
            overflow_flag <= (acc[7] == op_eff[7]) && (alu_result[7] != acc[7]);
        end else if (bit_test_valid) begin
            overflow_flag <= bit_test_data[6];
        end else if (clear_overflow_instr) begin
            overflow_flag <= 1'b0;
        end else if (apb_wr && paddr == OFS_STATUS) begin
            overflow_flag <= pwdata[STAT_OVF];
        end
    end

    // user flag and bank selects, software controlled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            general_user_flag <= STATUS_RESET[STAT_USER];
            bank_select_high <= STATUS_RESET[STAT_BANK_HI];
            bank_select_low <= STATUS_RESET[STAT_BANK_LO];
        end else if (apb_wr && paddr == OFS_STATUS) begin
            general_user_flag <= pwdata[STAT_USER];
            bank_select_high <= pwdata[STAT_BANK_HI];
            bank_select_low <= pwdata[STAT_BANK_LO];
        end
    end

    // program counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc <= PC_RESET;
        end else if (pc_load) begin
            pc <= pc_load_value;
        end else if (pc_inc) begin
            pc <= pc + 16'h0001;
        end else if (apb_wr && paddr == OFS_PROG_CNT_LO) begin
            pc[7:0] <= pwdata[7:0];
        end else if (apb_wr && paddr == OFS_PROG_CNT_HI) begin
            pc[15:8] <= pwdata[7:0];
        end
    end

    // stack pointer; wraps inside the lower half so the stack never leaves it
    logic [7:0] next_sp_push;
    logic [7:0] push_addr;
    assign next_sp_push = {1'b0, stack_pointer[6:0] + 7'h01};
    assign push_addr = next_sp_push;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_pointer <= STACK_PTR_RESET;
        end else if (stack_push) begin
            stack_pointer <= next_sp_push;
        end else if (stack_pop) begin
            stack_pointer <= {1'b0, stack_pointer[6:0] - 7'h01};
        end else if (apb_wr && paddr == OFS_STACK_PTR) begin
            stack_pointer <= {1'b0, pwdata[6:0]};
        end
    end
    assign stack_rdata = iram[{1'b0, stack_pointer[6:0]}];

    // data pointer, byte halves reachable separately
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_pointer <= 16'h0000;
        end else if (data_pointer_we) begin
            data_pointer <= data_pointer_wdata;
        end else if (data_pointer_inc) begin
            data_pointer <= data_pointer + 16'h0001;
        end else if (apb_wr && paddr == OFS_DATA_PTR_LO) begin
            data_pointer[7:0] <= pwdata[7:0];
        end else if (apb_wr && paddr == OFS_DATA_PTR_HI) begin
            data_pointer[15:8] <= pwdata[7:0];
        end
    end

    // working register and bit area addressing
    logic [7:0] work_addr;
    logic [7:0] bit_byte_addr;
    logic [7:0] bit_byte_new;
    assign work_addr = {3'b000, bank_select_high, bank_select_low, work_reg_index};
    assign bit_byte_addr = BIT_AREA_BASE + {4'h0, bit_addr[6:3]};
    assign work_reg_rdata = iram[work_addr];
    assign bit_rdata = iram[bit_byte_addr][bit_addr[2:0]];
    always_comb begin
        bit_byte_new = iram[bit_byte_addr];
        bit_byte_new[bit_addr[2:0]] = bit_wdata;
    end

    // single internal ram write port, core sources before software
    logic iram_we;
    logic [7:0] iram_waddr;
    logic [7:0] iram_wdata;
    always_comb begin
        iram_we = 1'b1;
        iram_waddr = push_addr;
        iram_wdata = stack_wdata;
        if (stack_push) begin
            iram_waddr = push_addr;
        end else if (work_reg_we) begin
            iram_waddr = work_addr;
            iram_wdata = work_reg_wdata;
        end else if (bit_we) begin
            iram_waddr = bit_byte_addr;
            iram_wdata = bit_byte_new;
        end else if (apb_wr && win_hit) begin
            iram_waddr = ram_addr_w;
            iram_wdata = pwdata[7:0];
        end else begin
            iram_we = 1'b0;
        end
    end

    always_ff @(posedge pclk) begin
        if (iram_we) begin
            iram[iram_waddr] <= iram_wdata;
        end
    end

    // extended control: only the select bit is stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_ram_select <= EXT_CTRL_RESET[0];
        end else if (apb_wr && paddr == OFS_EXT_CTRL) begin
            aux_ram_select <= pwdata[0];
        end
    end

    // external move decode; data_pointer above 255 and ri with select set find nothing,
    // because there is no external bus to send them to
    logic external_move_instr_hit;
    logic [7:0] external_move_instr_addr;
    assign external_move_instr_addr = external_move_instr_use_data_pointer ? data_pointer[7:0] : external_move_instr_ri_addr;
    // data_pointer when its high byte is zero, or ri when select low
    assign external_move_instr_hit = external_move_instr &&
        (external_move_instr_use_data_pointer ? (data_pointer[15:8] == 8'h00) : !aux_ram_select);
    logic buf_access;  // software access to the io buffer
    assign buf_access = apb_access && !pslverr && (paddr == OFS_AUX_BUF);

    // aux ram write port; the core move wins over software buffer writes
    always_ff @(posedge pclk) begin
        if (external_move_instr_hit && external_move_instr_write) begin
            aux_ram[external_move_instr_addr] <= external_move_instr_wdata;
        end else if (buf_access && pwrite) begin
            aux_ram[aux_ram_address_pointer] <= pwdata[7:0];
        end
    end

    // external move read data; a miss reads as all ones, pins stay untouched
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            external_move_instr_rdata <= 8'h00;
        end else if (external_move_instr && !external_move_instr_write) begin
            external_move_instr_rdata <= external_move_instr_hit ? aux_ram[external_move_instr_addr] : 8'hff;
        end
    end

    // address pointer with post-increment after each buffer access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_ram_address_pointer <= 8'h00;
        end else if (buf_access) begin
            aux_ram_address_pointer <= aux_ram_address_pointer + 8'h01;
        end else if (apb_wr && paddr == OFS_AUX_PTR) begin
            aux_ram_address_pointer <= pwdata[7:0];
        end
    end

    // read mux; the buffer reads the byte the pointer held before its step
    always_comb begin
        prdata = 32'h0000_0000;
        if (apb_rd && win_hit) begin
            prdata[7:0] = iram[ram_addr_w];
        end else if (apb_rd) begin
            case (paddr)
                OFS_STATUS: prdata[7:0] = program_status_word;
                OFS_EXT_CTRL: prdata[7:0] = {7'h00, aux_ram_select};
                OFS_ACC: prdata[7:0] = acc;
                OFS_B: prdata[7:0] = b_reg;
                OFS_STACK_PTR: prdata[7:0] = stack_pointer;
                OFS_DATA_PTR_LO: prdata[7:0] = data_pointer[7:0];
                OFS_DATA_PTR_HI: prdata[7:0] = data_pointer[15:8];
                OFS_PROG_CNT_LO: prdata[7:0] = pc[7:0];
                OFS_PROG_CNT_HI: prdata[7:0] = pc[15:8];
                OFS_AUX_PTR: prdata[7:0] = aux_ram_address_pointer;
                OFS_AUX_BUF: prdata[7:0] = aux_ram[aux_ram_address_pointer];
                default: prdata = 32'h0000_0000;
            endcase
        end
    end

    // checks on the register behaviour
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_pc_reset_value: assert property (
        $rose(presetn) |-> pc == PC_RESET) else $error("pc not at reset address");
    a_parity_follows: assert property (
        alu_valid |=> program_status_word[STAT_PARITY] == ~(^$past(alu_result)))
        else $error("parity does not follow accumulator");
    a_carry_capture: assert property (
        alu_valid |=> carry_flag == $past(add_full[8])) else $error("carry not captured");
    a_aux_carry_bit3: assert property (
        alu_valid |=> aux_carry_flag == $past(add_low[4])) else $error("aux carry wrong");
    a_overflow_clear: assert property (
        clear_overflow_instr && !alu_valid && !bit_test_valid |=> !overflow_flag)
        else $error("overflow not cleared");
    a_bit_test_copy: assert property (
        bit_test_valid && !alu_valid |=> overflow_flag == $past(bit_test_data[6]))
        else $error("bit test did not copy bit 6");
    a_stack_range: assert property (
        stack_push |=> stack_pointer[7] == 1'b0 && iram[stack_pointer] == $past(stack_wdata))
        else $error("stack push outside range");
    a_ptr_increment: assert property (
        buf_access |=> aux_ram_address_pointer == $past(aux_ram_address_pointer) + 8'h01)
        else $error("pointer did not step");
    a_bank_write: assert property (
        work_reg_we && !stack_push |=> iram[$past(work_addr)] == $past(work_reg_wdata))
        else $error("bank register write lost");
    a_ext_ctrl_bits: assert property (
        apb_rd && paddr == OFS_EXT_CTRL |-> prdata[7:1] == 7'h00)
        else $error("unassigned control bits not zero");

    c_push_pop: cover property (stack_push ##[1:4] stack_pop);
    c_buf_burst: cover property (buf_access ##[1:3] buf_access);
    c_signed_ovf: cover property (alu_valid ##1 overflow_flag);
    c_external_move_instr_miss: cover property (external_move_instr && !external_move_instr_hit);
endmodule
`default_nettype wire

// ===== include/cpu_regs_pkg.sv
// constants and register map for the cpu register set and data memory
// Summary of operation
// - program memory read-only, 32k bytes
// - internal ram holds 256 read/write bytes
// - accumulator 8 bits, pairs with b
// - b register helps multiply and divide
// - stack lives within 0x00 to 0x7f
// - program counter 16 bits, resets 0xfffe
// - carry takes alu carry or shift
// - aux carry from bit 3 carry
// - two bank bits pick 8-byte bank
// - overflow on signed range exceed
// - overflow cleared by instruction, bit-test copies
// - parity is one when ones even
// - four banks in bytes 0 to 31
// - bytes 32-47 give 128 bits
// - aux ram via pointer, buffer, autoincrement
// - external moves reach aux ram too
// - aux ram access leaves port pins alone
// - extended control keeps only bit 0
// - data pointer 16 bits, two bytes
// - status word resets to 0x01, only parity set
package cpu_regs_pkg;
    // apb byte offsets of the register words
    localparam logic [11:0] OFS_STATUS = 12'h000;
    localparam logic [11:0] OFS_EXT_CTRL = 12'h004;
    localparam logic [11:0] OFS_ACC = 12'h008;
    localparam logic [11:0] OFS_B = 12'h00c;
    localparam logic [11:0] OFS_STACK_PTR = 12'h010;
    localparam logic [11:0] OFS_DATA_PTR_LO = 12'h014;
    localparam logic [11:0] OFS_DATA_PTR_HI = 12'h018;
    localparam logic [11:0] OFS_PROG_CNT_LO = 12'h01c;
    localparam logic [11:0] OFS_PROG_CNT_HI = 12'h020;
    localparam logic [11:0] OFS_AUX_PTR = 12'h024;
    localparam logic [11:0] OFS_AUX_BUF = 12'h028;
    // internal ram window: 256 words from here, address bits [11:10] = 01
    localparam logic [1:0] IRAM_WINDOW_SEL = 2'b01;
    // status word field positions
    localparam int STAT_CARRY = 7;
    localparam int STAT_AUX_CARRY = 6;
    localparam int STAT_USER = 5;
    localparam int STAT_BANK_HI = 4;
    localparam int STAT_BANK_LO = 3;
    localparam int STAT_OVF = 2;
    localparam int STAT_PARITY = 0;
    // reset values
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] STACK_PTR_RESET = 8'h07;
    localparam logic [15:0] PC_RESET = 16'hfffe;
    localparam logic [7:0] EXT_CTRL_RESET = 8'h00;
    // memory geometry
    localparam int IRAM_DEPTH = 256;
    localparam int AUX_DEPTH = 256;
    localparam int PROG_ADDR_W = 15;
    localparam logic [7:0] BIT_AREA_BASE = 8'h20;
endpackage

// ===== testbench/cpu_core_model.sv
// behavioural model of the instruction core that drives the register file
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
    input wire logic pclk,
    output logic pc_load,
    output logic [15:0] pc_load_value,
    output logic pc_inc,
    output logic alu_valid,
    output logic alu_sub,
    output logic [7:0] alu_operand,
    output logic alu_use_carry,
    output logic shift_valid,
    output logic shift_carry,
    output logic [7:0] shift_result,
    output logic acc_we,
    output logic [7:0] acc_wdata,
    output logic b_we,
    output logic [7:0] b_wdata,
    output logic clear_overflow_instr,
    output logic bit_test_valid,
    output logic [7:0] bit_test_data,
    output logic stack_push,
    output logic stack_pop,
    output logic [7:0] stack_wdata,
    output logic work_reg_we,
    output logic [2:0] work_reg_index,
    output logic [7:0] work_reg_wdata,
    output logic bit_we,
    output logic [6:0] bit_addr,
    output logic bit_wdata,
    output logic data_pointer_we,
    output logic [15:0] data_pointer_wdata,
    output logic data_pointer_inc,
    output logic external_move_instr,
    output logic external_move_instr_write,
    output logic external_move_instr_use_data_pointer,
    output logic [7:0] external_move_instr_ri_addr,
    output logic [7:0] external_move_instr_wdata
);
    // one-hot strobes, only one request per cycle
    logic [14:0] str;
    // operand word; fields overlap since one request is live at a time
    logic [23:0] dat;
    initial begin
        str = '0;
        dat = '0;
    end
    assign {external_move_instr, data_pointer_inc, data_pointer_we, bit_we, work_reg_we, stack_pop, stack_push,
        bit_test_valid, clear_overflow_instr, b_we, acc_we, shift_valid, alu_valid, pc_inc,
        pc_load} = str;
    assign {acc_wdata, b_wdata, alu_operand, shift_result, bit_test_data, stack_wdata,
        work_reg_wdata, external_move_instr_wdata} = {8{dat[7:0]}};
    assign {data_pointer_wdata, pc_load_value} = {2{dat[15:0]}};
    assign {alu_sub, shift_carry, bit_wdata, external_move_instr_write} = {4{dat[16]}};
    assign {alu_use_carry, external_move_instr_use_data_pointer} = {2{dat[17]}};
    assign work_reg_index = dat[10:8];
    assign bit_addr = dat[14:8];
    assign external_move_instr_ri_addr = dat[15:8];
    // a request stands for exactly one cycle, data held afterwards
    task cmd(input int k, input logic [23:0] d);
        @(posedge pclk);
        dat <= d;
        str <= 15'h0001 << k;
        @(posedge pclk);
        str <= '0;
    endtask
endmodule
`default_nettype wire

// ===== testbench/tb_cpu_register_file.sv
// self-checking bench for the cpu register file over apb and core strobes
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_register_file;
    import cpu_regs_pkg::*;
    // strobe positions in the core model
    localparam int K_PCL = 0, K_PCI = 1, K_ALU = 2, K_SHF = 3, K_ACC = 4, K_B = 5, K_CLV = 6;
    localparam int K_BT = 7, K_PSH = 8, K_POP = 9, K_WR = 10, K_BIT = 11, K_DPW = 12;
    localparam int K_DPI = 13, K_MVX = 14;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [PROG_ADDR_W-1:0] prog_addr;
    logic pc_load, pc_inc, alu_valid, alu_sub, alu_use_carry, shift_valid, shift_carry;
    logic acc_we, b_we, clear_overflow_instr, bit_test_valid, stack_push, stack_pop, rerr;
    logic work_reg_we, bit_we, bit_wdata, bit_rdata, data_pointer_we, data_pointer_inc;
    logic external_move_instr, external_move_instr_write, external_move_instr_use_data_pointer;
    logic [15:0] pc_load_value, data_pointer_wdata, ba_pair;
    logic [7:0] alu_operand, shift_result, acc_wdata, b_wdata, bit_test_data, stack_wdata;
    logic [7:0] stack_rdata, work_reg_wdata, work_reg_rdata, external_move_instr_ri_addr, external_move_instr_wdata;
    logic [7:0] external_move_instr_rdata, acc, b_reg, program_status_word;
    logic [6:0] bit_addr;
    logic [2:0] work_reg_index;
    // register map and values expected after reset (p reads 1 with acc zero)
    logic [11:0] rmap [10] = '{OFS_STATUS, OFS_EXT_CTRL, OFS_ACC, OFS_B, OFS_STACK_PTR,
        OFS_DATA_PTR_LO, OFS_DATA_PTR_HI, OFS_PROG_CNT_LO, OFS_PROG_CNT_HI, OFS_AUX_PTR};
    logic [7:0] rrst [10] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'hfe, 8'hff,
        8'h00};
    int n_fail = 0;
    int n_compared = 0;
    cpu_register_file cpu_register_file_inst (.*);
    cpu_core_model cpu_core_model_inst (.*);
    // bus clock, 10 ns period
    initial pclk = 1'b0;
    always #5 pclk = ~pclk;
    task end_of_test;
        if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // one apb transfer: setup cycle, then access held until pready
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk($sformatf("reg %h", a), {24'h000000, e}, rdat);
    endtask
    // internal ram byte n sits in the word window
    function automatic logic [11:0] ram(input logic [7:0] n);
        return {IRAM_WINDOW_SEL, n, 2'b00};
    endfunction
    // core request, then let its edge settle before looking
    task core(input int k, input logic [23:0] d);
        cpu_core_model_inst.cmd(k, d);
        #1;
    endtask
    task step(input int k, input logic [23:0] d, input logic [7:0] ea, input logic [7:0] ep);
        core(k, d);
        chk("acc", 32'(ea), 32'(acc));
        chk("status", 32'(ep), 32'(program_status_word));
    endtask
    // watchdog far beyond the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge pclk);
        n_fail++;
        end_of_test();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 10; i++) rd(rmap[i], rrst[i]);
        chk("prog_addr", 32'h7ffe, 32'(prog_addr));
        // unmapped word refused, nothing written
        wr(12'h030, 8'h5a);
        chk("pslverr", 32'h1, 32'(rerr));
        // flag behaviour on add, subtract, clear, bit test and shift
        step(K_ACC, 24'h00007f, 8'h7f, 8'h00);
        step(K_ALU, 24'h000001, 8'h80, 8'h44);
        step(K_ALU, 24'h000080, 8'h00, 8'h85);
        step(K_ALU, 24'h020000, 8'h01, 8'h00);
        step(K_ALU, 24'h010002, 8'hff, 8'h01);
        step(K_ALU, 24'h01007f, 8'h80, 8'hc0);
        step(K_ALU, 24'h010001, 8'h7f, 8'h84);
        step(K_CLV, 24'h000000, 8'h7f, 8'h80);
        step(K_BT, 24'h000040, 8'h7f, 8'h84);
        step(K_BT, 24'h0000bf, 8'h7f, 8'h80);
        step(K_SHF, 24'h010006, 8'h06, 8'h81);
        step(K_SHF, 24'h000003, 8'h03, 8'h01);
        core(K_B, 24'h000034);
        chk("ba_pair", 32'h3403, 32'(ba_pair));
        rd(OFS_B, 8'h34);
        wr(OFS_STATUS, 8'hff);
        rd(OFS_STATUS, 8'hfd);
        // each bank in turn takes working register 5
        for (int b = 0; b < 4; b++) begin
            wr(OFS_STATUS, 8'(b << 3));
            core(K_WR, 24'h0005a0 + 24'(b));
            chk("wreg", 32'ha0 + 32'(b), 32'(work_reg_rdata));
            rd(ram(8'(8 * b + 5)), 8'(8'ha0 + b));
        end
        // bit area corners
        wr(ram(8'h20), 8'h00);
        wr(ram(8'h21), 8'h00);
        wr(ram(8'h2f), 8'h00);
        core(K_BIT, 24'h017f00);
        core(K_BIT, 24'h010000);
        core(K_BIT, 24'h010b00);
        chk("bit", 32'h1, 32'(bit_rdata));
        rd(ram(8'h2f), 8'h80);
        rd(ram(8'h20), 8'h01);
        rd(ram(8'h21), 8'h08);
        // stack from the customary start, then wrap at the top
        wr(OFS_STACK_PTR, 8'h07);
        core(K_PSH, 24'h00005a);
        rd(OFS_STACK_PTR, 8'h08);
        rd(ram(8'h08), 8'h5a);
        wr(OFS_STACK_PTR, 8'hff);
        rd(OFS_STACK_PTR, 8'h7f);
        core(K_PSH, 24'h000066);
        chk("stack", 32'h66, 32'(stack_rdata));
        core(K_POP, 24'h000000);
        rd(OFS_STACK_PTR, 8'h7f);
        // aux ram through pointer and buffer, pointer wraps
        wr(OFS_EXT_CTRL, 8'hff);
        rd(OFS_EXT_CTRL, 8'h01);
        wr(OFS_AUX_PTR, 8'hff);
        wr(OFS_AUX_BUF, 8'h11);
        wr(OFS_AUX_BUF, 8'h22);
        rd(OFS_AUX_PTR, 8'h01);
        wr(OFS_AUX_PTR, 8'hff);
        rd(OFS_AUX_BUF, 8'h11);
        rd(OFS_AUX_BUF, 8'h22);
        // external moves by data pointer and by indirect register
        core(K_DPW, 24'h0000ff);
        rd(OFS_DATA_PTR_LO, 8'hff);
        core(K_MVX, 24'h020000);
        chk("external_move_instr", 32'h11, 32'(external_move_instr_rdata));
        core(K_MVX, 24'h000000);
        chk("external_move_instr", 32'hff, 32'(external_move_instr_rdata));
        wr(OFS_EXT_CTRL, 8'h00);
        core(K_MVX, 24'h000000);
        chk("external_move_instr", 32'h22, 32'(external_move_instr_rdata));
        core(K_MVX, 24'h010577);
        wr(OFS_AUX_PTR, 8'h05);
        rd(OFS_AUX_BUF, 8'h77);
        core(K_DPI, 24'h000000);
        rd(OFS_DATA_PTR_HI, 8'h01);
        core(K_MVX, 24'h020000);
        chk("external_move_instr", 32'hff, 32'(external_move_instr_rdata));
        // program counter load and step
        core(K_PCL, 24'h001234);
        core(K_PCI, 24'h000000);
        chk("prog_addr", 32'h1235, 32'(prog_addr));
        rd(OFS_PROG_CNT_HI, 8'h12);
        end_of_test();
    end
endmodule
`default_nettype wire
